// *** eeprom_read_seq.sv ***
// two-wire serial memory slave: addressing, set-current-address and reads
//
// Notes on behaviour
// - on a matched read address the device acknowledges, then sends eight data bits
// - stop after address bytes loads the counter and sends no data
// - after that stop the device idles, ignoring the bus until a start
// - next current-address read returns the location loaded by set-current-address
// - sequential read may start as current-address or random read
// - each master acknowledge of a read byte brings another byte
// - byte at n is followed by byte at n plus one, across pages
// - read counter walks every byte address of the whole array
// - past the top address the counter wraps to zero and reads continue
// - page is byte 1 bits 4..0 with byte 0 bits 7..5; bits 4..0 pick the byte
// - slave address: type field, three select bits matching pins, direction bit
// - receiver acknowledges by pulling data low in the ninth clock
`timescale 1ns/100ps
`include "eeprom_rd_cfg.svh"
module eeprom_read_seq
    import eeprom_rd_pkg::*;
#(
    parameter logic [`TYPE_W-1:0] DEV_TYPE = `DEV_TYPE_DEFAULT, // value is arbitrary
    parameter int DEPTH = `MEM_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [`SEL_W-1:0] sel,
    input wire fill_t fill
);
    // link-side synchronisers for the pins and the answer toggle
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic [`SEL_W-1:0] sel_s1, sel_s2;
    logic rsp_s1, rsp_s2, rsp_d;

    // link-side state
    link_state_t state, next_state;
    phase_t phase, next_phase;
    logic [`BIT_CNT_W-1:0] bitcnt, next_bitcnt;
    logic [`DATA_W-1:0] sh, next_sh;
    logic [`DATA_W-1:0] tx_byte, next_tx_byte;
    logic [`HI_KEEP_W-1:0] hi, next_hi;
    logic [`ADDR_W-1:0] cnt, next_cnt;
    logic [`ADDR_W-1:0] req_addr, next_req_addr;
    logic req_tgl, next_req_tgl;
    logic rd, next_rd;
    logic ack_drv, next_ack_drv;
    logic oe, next_oe;

    // core-side state
    logic req_s1, req_s2, req_d;
    logic rd_go, next_rd_go;
    logic rsp_tgl, next_rsp_tgl;
    logic [`DATA_W-1:0] rsp_data, next_rsp_data;
    logic [`DATA_W-1:0] mem_rdata;
    logic mem_rd_en;

    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [`DATA_W-1:0] in_byte;
    logic dev_match;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            sel_s1 <= '0;
            sel_s2 <= '0;
            rsp_s1 <= 1'b0;
            rsp_s2 <= 1'b0;
            rsp_d <= 1'b0;
        end else begin
            scl_s1 <= scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            sel_s1 <= sel;
            sel_s2 <= sel_s1;
            rsp_s1 <= rsp_tgl;
            rsp_s2 <= rsp_s1;
            rsp_d <= rsp_s2;
        end
    end

    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    // data edges while the clock stays high mark start and stop
    assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign in_byte = {sh[`DATA_W-2:0], sda_s2};
    assign dev_match = (in_byte[`TYPE_MSB:`TYPE_LSB] == DEV_TYPE)
        && (in_byte[`SEL_MSB:`SEL_LSB] == sel_s2);

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_bitcnt = bitcnt;
        next_sh = sh;
        next_tx_byte = tx_byte;
        next_hi = hi;
        next_cnt = cnt;
        next_req_addr = req_addr;
        next_req_tgl = req_tgl;
        next_rd = rd;
        next_ack_drv = ack_drv;
        next_oe = oe;
        if (rsp_s2 ^ rsp_d) begin
            next_tx_byte = rsp_data;
        end
        if (bus_stop) begin
            // standby until the next start
            next_state = st_idle;
            next_ack_drv = 1'b0;
            next_oe = 1'b0;
        end else if (bus_start) begin
            // a repeated start keeps the counter, so random reads follow
            next_state = st_rx;
            next_phase = ph_dev;
            next_bitcnt = '0;
            next_ack_drv = 1'b0;
            next_oe = 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    next_oe = 1'b0;
                end
                st_rx: begin
                    if (scl_rise) begin
                        next_sh = in_byte;
                        next_bitcnt = bitcnt + 4'h1;
                        if (bitcnt == `BIT_LAST) begin
                            next_state = st_ack;
                            case (phase)
                                ph_dev: begin
                                    if (dev_match) begin
                                        next_rd = in_byte[`DIR_POS];
                                        if (in_byte[`DIR_POS]) begin
                                            // fetch the current-address byte
                                            next_req_tgl = ~req_tgl;
                                            next_req_addr = cnt;
                                            next_cnt = cnt + `ADDR_STEP;
                                        end
                                    end else begin
                                        next_state = st_idle;
                                    end
                                end
                                ph_hi: begin
                                    next_hi = in_byte[`HI_KEEP_MSB:0];
                                end
                                ph_lo: begin
                                    next_cnt = {hi, in_byte};
                                end
                                default: begin
                                    // data bytes of a write are not taken
                                    next_state = st_idle;
                                end
                            endcase
                        end
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        if (!ack_drv) begin
                            next_ack_drv = 1'b1;
                            next_oe = 1'b1;
                        end else begin
                            next_ack_drv = 1'b0;
                            next_bitcnt = '0;
                            if (rd) begin
                                next_state = st_tx;
                                next_sh = tx_byte;
                                next_oe = ~tx_byte[`DATA_W-1];
                            end else begin
                                next_state = st_rx;
                                next_oe = 1'b0;
                                next_phase = phase_t'(phase + 2'h1);
                            end
                        end
                    end
                end
                st_tx: begin
                    if (scl_rise) begin
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (bitcnt == `BIT_DONE) begin
                            // release for the master's acknowledge slot
                            next_state = st_mack;
                            next_oe = 1'b0;
                        end else begin
                            next_sh = {sh[`DATA_W-2:0], 1'b0};
                            next_oe = ~sh[`DATA_W-2];
                        end
                    end
                end
                st_mack: begin
                    if (scl_rise) begin
                        if (!sda_s2) begin
                            next_ack_drv = 1'b1;
                            next_req_tgl = ~req_tgl;
                            next_req_addr = cnt;
                            next_cnt = cnt + `ADDR_STEP;
                        end else begin
                            // no acknowledge: stop sending, wait for stop or start
                            next_state = st_idle;
                        end
                    end
                    if (scl_fall && ack_drv) begin
                        next_ack_drv = 1'b0;
                        next_state = st_tx;
                        next_bitcnt = '0;
                        next_sh = tx_byte;
                        next_oe = ~tx_byte[`DATA_W-1];
                    end
                end
                default: begin
                    next_state = st_idle;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= st_idle;
            phase <= ph_dev;
            bitcnt <= '0;
            sh <= '0;
            tx_byte <= '0;
            hi <= '0;
            cnt <= `CNT_RST;
            req_addr <= `CNT_RST;
            req_tgl <= 1'b0;
            rd <= 1'b0;
            ack_drv <= 1'b0;
            oe <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bitcnt <= next_bitcnt;
            sh <= next_sh;
            tx_byte <= next_tx_byte;
            hi <= next_hi;
            cnt <= next_cnt;
            req_addr <= next_req_addr;
            req_tgl <= next_req_tgl;
            rd <= next_rd;
            ack_drv <= next_ack_drv;
            oe <= next_oe;
            sda_oe <= next_oe;
            sda_o <= 1'b0;
        end
    end

    // core side: toggle request in, one array read, toggle answer out
    assign mem_rd_en = req_s2 ^ req_d;

    always_comb begin
        next_rd_go = mem_rd_en;
        next_rsp_tgl = rd_go ? ~rsp_tgl : rsp_tgl;
        next_rsp_data = rd_go ? mem_rdata : rsp_data;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_d <= 1'b0;
            rd_go <= 1'b0;
            rsp_tgl <= 1'b0;
            rsp_data <= '0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_d <= req_s2;
            rd_go <= next_rd_go;
            rsp_tgl <= next_rsp_tgl;
            rsp_data <= next_rsp_data;
        end
    end

    // req_addr is held still from the toggle until the answer returns
    eeprom_array #(
        .DATA_W(`DATA_W),
        .DEPTH(DEPTH),
        .ADDR_W(`ADDR_W)
    ) u_array (
        .clk(clk),
        .wr_en(fill.en),
        .wr_addr(fill.addr),
        .wr_data(fill.data),
        .rd_en(mem_rd_en),
        .rd_addr(req_addr),
        .rd_data(mem_rdata)
    );
endmodule

// *** eeprom_rd_cfg.svh ***
// constants for the serial memory read sequencer
`ifndef EEPROM_RD_CFG_SVH
`define EEPROM_RD_CFG_SVH

`define ADDR_W 13
`define DATA_W 8
`define MEM_DEPTH 8192
`define SEL_W 3
`define TYPE_W 4
`define BIT_CNT_W 4
`define BIT_LAST 4'h7
`define BIT_DONE 4'h8
`define DIR_POS 0
`define SEL_LSB 1
`define SEL_MSB 3
`define TYPE_LSB 4
`define TYPE_MSB 7
`define HI_KEEP_MSB 4
`define HI_KEEP_W 5
`define CNT_RST 13'h0000
`define ADDR_STEP 13'h0001
`define DEV_TYPE_DEFAULT 4'h5 // value is arbitrary

`endif

// *** eeprom_rd_pkg.sv ***
// types shared by the read sequencer and its testbench
package eeprom_rd_pkg;
`include "eeprom_rd_cfg.svh"

    typedef enum logic [4:0] {
        st_idle = 5'h01,
        st_rx = 5'h02,
        st_ack = 5'h04,
        st_tx = 5'h08,
        st_mack = 5'h10
    } link_state_t;

    typedef enum logic [1:0] {
        ph_dev = 2'h0,
        ph_hi = 2'h1,
        ph_lo = 2'h2,
        ph_data = 2'h3
    } phase_t;

    typedef struct packed {
        logic en;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } fill_t;
endpackage

// *** eeprom_array.sv ***
// byte array with one write port and a registered read port
`timescale 1ns/100ps
module eeprom_array #(
    parameter int DATA_W = 8,
    parameter int DEPTH = 8192,
    parameter int ADDR_W = 13
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** eeprom_read_seq_chk.sv ***
// assertions on the pins of the read sequencer
`timescale 1ns/100ps
`include "eeprom_rd_cfg.svh"
module eeprom_read_seq_chk
    import eeprom_rd_pkg::*;
#(
    parameter logic [`TYPE_W-1:0] DEV_TYPE = `DEV_TYPE_DEFAULT,
    parameter int DEPTH = `MEM_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [`SEL_W-1:0] sel
);
    logic scl_q, sda_q, first, rd;
    logic [7:0] sh;
    logic [3:0] nb;
    wire logic rise = scl && !scl_q;
    wire logic sta = scl && scl_q && sda_q && !sda_i;
    wire logic sto = scl && scl_q && !sda_q && sda_i;
    wire logic hit = sh[7:4] == DEV_TYPE && sh[3:1] == sel;
    // bit count of the current byte as the master clocks it
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            {first, rd, sh, nb} <= '0;
            // idle bus level, so no false edge follows reset
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_i;
            if (sta || sto) begin
                nb <= 4'h0;
                first <= sta;
                rd <= 1'b0;
            end else if (rise) begin
                sh <= {sh[6:0], sda_i};
                nb <= (nb == 4'h8) ? 4'h0 : nb + 4'h1;
                first <= first && nb != 4'h8;
                rd <= rd || (first && nb == 4'h8 && hit && sh[0]);
            end
        end
    end
    default clocking @(posedge link_clk); endclocking
    default disable iff (!arst_n);
    property p_low; sda_o == 1'b0; endproperty
    a_low: assert property (p_low) else $error("sda_o not low");
    property p_fall; $changed(sda_oe) |-> !scl && $past(scl, 6); endproperty
    a_fall: assert property (p_fall) else $error("sda_oe moved off a clock fall");
    property p_hold; $rose(sda_oe) |-> sda_oe [*8]; endproperty
    a_hold: assert property (p_hold) else $error("low level too short");
    property p_stop; sto |-> !sda_oe [*8]; endproperty
    a_stop: assert property (p_stop) else $error("driving after stop");
    property p_miss; first && nb == 4'h8 && !hit |-> !sda_oe [*8]; endproperty
    a_miss: assert property (p_miss) else $error("ack on foreign address");
    property p_hit; first && nb == 4'h8 && hit && $fell(scl) |-> ##[1:8] sda_oe; endproperty
    a_hit: assert property (p_hit) else $error("no ack on own address");
    property p_rel; rd && nb == 4'h8 && $fell(scl) |-> ##[1:8] !sda_oe; endproperty
    a_rel: assert property (p_rel) else $error("line kept in ack slot");
    property p_nack; rd && nb == 4'h8 && rise && sda_i |=> !sda_oe [*8]; endproperty
    a_nack: assert property (p_nack) else $error("data sent after nack");
endmodule
bind eeprom_read_seq eeprom_read_seq_chk #(.DEV_TYPE(DEV_TYPE), .DEPTH(DEPTH)) u_chk (
    .clk(clk), .arst_n(arst_n), .link_clk(link_clk), .scl(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .sel(sel));

// *** bus_master.sv ***
// two-wire bus master model that drives the clock
`timescale 1ns/100ps
module bus_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // one bit slot; data moves only while the clock is low
    task automatic xfer(input logic b, output logic r);
        if (scl) #100 scl = 1'b0;
        #20 sda_drv = b;
        #80 scl = 1'b1;
        #50 r = sda;
        #50 scl = 1'b0;
    endtask
    task automatic start();
        #20 sda_drv = 1'b1;
        #100 scl = 1'b1;
        #100 sda_drv = 1'b0;
        #100 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda_drv = 1'b0;
        #100 scl = 1'b1;
        #100 sda_drv = 1'b1;
        #100;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) xfer(b[i], ack);
        xfer(1'b1, ack);
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(!more, r);
    endtask
endmodule

// *** testbench.sv ***
// testbench for the serial memory read sequencer
`timescale 1ns/100ps
`include "eeprom_rd_cfg.svh"
module testbench
    import eeprom_rd_pkg::*;
;
    typedef struct packed {
        logic set;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [2:0] n;
        logic [12:0] a;
    } row_t;
    localparam logic [`TYPE_W-1:0] TYPE = 4'h9; // value is arbitrary
    row_t tbl [4] = '{'{1'b0, 8'h12, 8'h34, 3'h1, 13'h1234},
        '{1'b0, 8'he0, 8'h1e, 3'h3, 13'h001e}, '{1'b0, 8'h1f, 8'hfe, 3'h4, 13'h1ffe},
        '{1'b1, 8'h05, 8'h67, 3'h2, 13'h0567}};
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [`SEL_W-1:0] sel = 3'h5;
    fill_t fill = '0;
    wire logic scl, m_sda, sda_o, sda_oe;
    wire logic sda = m_sda & ~sda_oe;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    eeprom_read_seq #(.DEV_TYPE(TYPE)) u_eeprom_read_seq (.clk(clk), .arst_n(arst_n),
        .link_clk(link_clk), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .sel(sel), .fill(fill));
    bus_master u_bus_master (.scl(scl), .sda_drv(m_sda), .sda(sda));
    task automatic end_sim();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] pat(input logic [12:0] a);
        return a[7:0] ^ {a[12:8], 3'h5};
    endfunction
    task automatic put(input logic [12:0] a);
        @(negedge clk);
        fill <= '{1'b1, a, pat(a)};
        @(negedge clk);
        fill.en <= 1'b0;
    endtask
    task automatic addr_wr(input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] b [3];
        logic k;
        b = '{{TYPE, sel, 1'b0}, hi, lo};
        u_bus_master.start();
        foreach (b[i]) begin
            u_bus_master.send(b[i], k);
            check({7'h0, k}, 8'h00);
        end
    endtask
    task automatic rd_cur(input logic [12:0] a, input int n);
        logic k;
        logic [7:0] d;
        u_bus_master.start();
        u_bus_master.send({TYPE, sel, 1'b1}, k);
        check({7'h0, k}, 8'h00);
        for (int i = 0; i < n; i++) begin
            u_bus_master.recv(i < n - 1, d);
            check(d, pat(a + 13'(i)));
        end
        u_bus_master.stop();
    endtask
    initial begin
        logic k;
        logic [7:0] bad [2];
        repeat (2) @(negedge clk);
        check({7'h0, sda_oe}, 8'h00);
        check({7'h0, sda_o}, 8'h00);
        arst_n = 1'b1;
        foreach (tbl[r]) begin
            for (int i = 0; i < tbl[r].n; i++) put(tbl[r].a + 13'(i));
        end
        put(13'h0021);
        put(13'h0022);
        foreach (tbl[r]) begin
            addr_wr(tbl[r].hi, tbl[r].lo);
            if (tbl[r].set) u_bus_master.stop();
            rd_cur(tbl[r].a, tbl[r].n);
        end
        // stray byte without a start after set-address
        addr_wr(8'h00, 8'h20);
        u_bus_master.stop();
        u_bus_master.send({TYPE, sel, 1'b1}, k);
        check({7'h0, k}, 8'h01);
        rd_cur(13'h0020, 1);
        bad = '{{TYPE, sel ^ 3'h1, 1'b1}, {TYPE ^ 4'h8, sel, 1'b1}};
        foreach (bad[i]) begin
            u_bus_master.start();
            u_bus_master.send(bad[i], k);
            check({7'h0, k}, 8'h01);
            u_bus_master.stop();
        end
        // a data byte after the address bytes is refused and leaves the counter
        addr_wr(8'h00, 8'h21);
        u_bus_master.send(8'h5a, k);
        check({7'h0, k}, 8'h01);
        u_bus_master.stop();
        @(negedge clk);
        sel = 3'h2;
        rd_cur(13'h0021, 1);
        // reset while the device still holds the acknowledge of its read address
        u_bus_master.start();
        u_bus_master.send({TYPE, sel, 1'b1}, k);
        @(negedge clk);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        check({7'h0, sda_oe}, 8'h00);
        check({7'h0, sda_o}, 8'h00);
        arst_n = 1'b1;
        repeat (4) @(posedge link_clk);
        u_bus_master.stop();
        rd_cur(13'h0000, 1);
        end_sim();
    end
endmodule
